//--- hdl/fqtr_top.sv
// Function
// - query byte only on low data lines
// - upper data byte reads zero in query
// - identification starts at word 0x10
// - words 0x10,0x11 give Q and R
// - ID string bytes 51,52,59
// - multi-byte fields least significant first
// - query command switches partition to query
// - manufacturer at 0, device at 1
// - offsets 0x04-0x0F reserved, no fields
// - system at 0x1B, geometry at 0x27
// - offset 0x15 holds extended table pointer
// - block base plus two gives status
// - status bit0 is block lock
// - status bit1 is block lock-down
// - status bits 2-7 read zero
// - block base is first word, 32K words
// - partition keeps mode until new command
// - all partitions start in array mode
`timescale 1ns/1ps
module fqtr_top #(
  parameter logic [7:0] MFR_CODE = 8'hA5, // Arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h5A // Arbitrary value
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [fqtr_pkg::ADDR_W-1:0] addr_i,
  input wire logic [fqtr_pkg::DATA_W-1:0] cmd_data_i,
  input wire logic cmd_we_i,
  input wire logic rd_i,
  input wire logic [fqtr_pkg::DATA_W-1:0] array_data_i,
  input wire logic [fqtr_pkg::BYTE_W-1:0] status_data_i,
  input wire logic [(1<<fqtr_pkg::BLK_W)-1:0] lock_flag_i,
  input wire logic [(1<<fqtr_pkg::BLK_W)-1:0] lockdown_flag_i,
  output logic [fqtr_pkg::BYTE_W-1:0] low_data_byte_lines_o,
  output logic [fqtr_pkg::BYTE_W-1:0] high_data_byte_lines_o,
  output logic rd_valid_o
);
  localparam int NPART = 1 << fqtr_pkg::PART_W;

  logic rst_meta_r;
  logic rst_sync_r;
  // Two-flop copies of every pin; the write strobe gets three
  logic [fqtr_pkg::ADDR_W-1:0] addr_s1_r;
  logic [fqtr_pkg::ADDR_W-1:0] addr_s2_r;
  logic [fqtr_pkg::DATA_W-1:0] cmd_s1_r;
  logic [fqtr_pkg::DATA_W-1:0] cmd_s2_r;
  logic [fqtr_pkg::DATA_W-1:0] arr_s1_r;
  logic [fqtr_pkg::DATA_W-1:0] arr_s2_r;
  logic [fqtr_pkg::BYTE_W-1:0] st_s1_r;
  logic [fqtr_pkg::BYTE_W-1:0] st_s2_r;
  logic [2:0] we_s_r;
  logic [1:0] rd_s_r;
  logic [(1<<fqtr_pkg::BLK_W)-1:0] lk_s1_r;
  logic [(1<<fqtr_pkg::BLK_W)-1:0] lk_s2_r;
  logic [(1<<fqtr_pkg::BLK_W)-1:0] ld_s1_r;
  logic [(1<<fqtr_pkg::BLK_W)-1:0] ld_s2_r;
  fqtr_pkg::fqtr_mode_e mode_r [NPART];
  // Read path
  logic [fqtr_pkg::BYTE_W-1:0] rom_byte;
  logic [fqtr_pkg::BYTE_W-1:0] bsr_byte;
  logic [fqtr_pkg::BYTE_W-1:0] qry_byte;
  logic [fqtr_pkg::PART_W-1:0] rd_part;
  logic [fqtr_pkg::PART_W-1:0] wr_part;
  logic we_rise;
  logic rd_sync;
  logic [fqtr_pkg::BYTE_W-1:0] cmd_code;
  logic cmd_take;
  fqtr_pkg::fqtr_mode_e rd_mode;

  function automatic logic [fqtr_pkg::PART_W-1:0] part_of(
    input logic [fqtr_pkg::ADDR_W-1:0] a
  );
    part_of = a[fqtr_pkg::PART_SHIFT +: fqtr_pkg::PART_W];
  endfunction

  // Only the four read-mode commands are recognised; others leave the mode alone
  function automatic logic known_cmd(
    input logic [fqtr_pkg::BYTE_W-1:0] code
  );
    case (code)
      fqtr_pkg::CMD_READ_ARRAY: known_cmd = 1'b1;
      fqtr_pkg::CMD_READ_ID: known_cmd = 1'b1;
      fqtr_pkg::CMD_QUERY: known_cmd = 1'b1;
      fqtr_pkg::CMD_READ_STATUS: known_cmd = 1'b1;
      default: known_cmd = 1'b0;
    endcase
  endfunction

  // ID and query share one output mode
  function automatic fqtr_pkg::fqtr_mode_e mode_of_cmd(
    input logic [fqtr_pkg::BYTE_W-1:0] code
  );
    case (code)
      fqtr_pkg::CMD_QUERY: mode_of_cmd = fqtr_pkg::FQTR_QUERY;
      fqtr_pkg::CMD_READ_ID: mode_of_cmd = fqtr_pkg::FQTR_QUERY;
      fqtr_pkg::CMD_READ_STATUS: mode_of_cmd = fqtr_pkg::FQTR_STATUS;
      default: mode_of_cmd = fqtr_pkg::FQTR_ARRAY;
    endcase
  endfunction

  // Status word: offset two inside any block
  function automatic logic is_status_word(
    input logic [fqtr_pkg::ADDR_W-1:0] a
  );
    is_status_word = a[fqtr_pkg::QRY_W-1:0] == fqtr_pkg::OFS_BSR
      && a[fqtr_pkg::BLK_OFF_W-1:fqtr_pkg::QRY_W] == '0;
  endfunction

  // Table words: the lowest query offsets of any block
  function automatic logic is_table_word(
    input logic [fqtr_pkg::ADDR_W-1:0] a
  );
    is_table_word = a[fqtr_pkg::BLK_OFF_W-1:fqtr_pkg::QRY_W] == '0;
  endfunction

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Pins are asynchronous to core_clk; every one passes two flops first
  always_ff @(posedge core_clk_i or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      addr_s1_r <= '0;
      addr_s2_r <= '0;
    end
    else
    begin
      addr_s1_r <= addr_i;
      addr_s2_r <= addr_s1_r;
    end
  end

  // Command word is only used at the strobe edge, after it has stood for clocks
  always_ff @(posedge core_clk_i or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      cmd_s1_r <= '0;
      cmd_s2_r <= '0;
    end
    else
    begin
      cmd_s1_r <= cmd_data_i;
      cmd_s2_r <= cmd_s1_r;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      arr_s1_r <= '0;
      arr_s2_r <= '0;
    end
    else
    begin
      arr_s1_r <= array_data_i;
      arr_s2_r <= arr_s1_r;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      st_s1_r <= '0;
      st_s2_r <= '0;
    end
    else
    begin
      st_s1_r <= status_data_i;
      st_s2_r <= st_s1_r;
    end
  end

  // The write strobe gets a third stage so that its rising edge can be seen
  always_ff @(posedge core_clk_i or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      we_s_r <= '0;
      rd_s_r <= '0;
    end
    else
    begin
      we_s_r <= {we_s_r[1:0], cmd_we_i};
      rd_s_r <= {rd_s_r[0], rd_i};
    end
  end

  // Lock levels are quasi-static; a change shows on the lines three clocks later
  always_ff @(posedge core_clk_i or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      lk_s1_r <= '0;
      lk_s2_r <= '0;
    end
    else
    begin
      lk_s1_r <= lock_flag_i;
      lk_s2_r <= lk_s1_r;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      ld_s1_r <= '0;
      ld_s2_r <= '0;
    end
    else
    begin
      ld_s1_r <= lockdown_flag_i;
      ld_s2_r <= ld_s1_r;
    end
  end

  // Edge taken from the second and third stages, never the first
  assign we_rise = we_s_r[1] & ~we_s_r[2];
  assign rd_sync = rd_s_r[1];
  assign cmd_code = cmd_s2_r[fqtr_pkg::BYTE_W-1:0];
  assign cmd_take = we_rise & known_cmd(cmd_code);
  // Writes and reads decode the partition from the same synchronised address
  assign wr_part = part_of(addr_s2_r);
  assign rd_part = part_of(addr_s2_r);
  assign rd_mode = mode_r[rd_part];

  // Per-partition output mode; only command writes change it
  always_ff @(posedge core_clk_i or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      for (int p = 0; p < NPART; p++)
      begin
        mode_r[p] <= fqtr_pkg::FQTR_ARRAY;
      end
    end
    else if (cmd_take)
    begin
      mode_r[wr_part] <= mode_of_cmd(cmd_code);
    end
    else
    begin
      // Unknown codes and idle cycles keep the partition's mode
      mode_r[wr_part] <= mode_r[wr_part];
    end
  end

  // Query space uses low word offsets; block status sits at block base + 2
  fqtr_rom u_rom (
    .ofs_i(addr_s2_r[fqtr_pkg::QRY_W-1:0]),
    .mfr_i(MFR_CODE),
    .dev_i(DEV_CODE),
    .byte_o(rom_byte)
  );

  fqtr_bsr u_bsr (
    .blk_i(addr_s2_r[fqtr_pkg::BLK_OFF_W +: fqtr_pkg::BLK_W]),
    .lock_i(lk_s2_r),
    .lockdown_i(ld_s2_r),
    .byte_o(bsr_byte)
  );

  // Any block base + 2 gives status; word 2 of block 0 likewise
  always_comb
  begin
    if (is_status_word(addr_s2_r))
    begin
      qry_byte = bsr_byte;
    end
    else if (is_table_word(addr_s2_r))
    begin
      qry_byte = rom_byte;
    end
    else
    begin
      qry_byte = fqtr_pkg::ZERO_BYTE;
    end
  end

  // Read path is pure selection: nothing here writes mode or lock state
  always_ff @(posedge core_clk_i or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      rd_valid_o <= 1'b0;
    end
    else
    begin
      rd_valid_o <= rd_sync;
    end
  end

  // Query and status bytes use the low lines only
  always_ff @(posedge core_clk_i or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      low_data_byte_lines_o <= '0;
    end
    else
    begin
      case (rd_mode)
        fqtr_pkg::FQTR_QUERY: low_data_byte_lines_o <= qry_byte;
        fqtr_pkg::FQTR_STATUS: low_data_byte_lines_o <= st_s2_r;
        default: low_data_byte_lines_o <= arr_s2_r[fqtr_pkg::BYTE_W-1:0];
      endcase
    end
  end

  // Upper lines carry data only in array mode
  always_ff @(posedge core_clk_i or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      high_data_byte_lines_o <= '0;
    end
    else
    begin
      case (rd_mode)
        fqtr_pkg::FQTR_QUERY: high_data_byte_lines_o <= fqtr_pkg::HIGH_BYTE_FILL;
        fqtr_pkg::FQTR_STATUS: high_data_byte_lines_o <= fqtr_pkg::HIGH_BYTE_FILL;
        default: high_data_byte_lines_o <= arr_s2_r[fqtr_pkg::DATA_W-1:fqtr_pkg::BYTE_W];
      endcase
    end
  end
endmodule

//--- hdl/fqtr_pkg.sv
package fqtr_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int PART_W = 4;
  localparam int BLK_W = 7;
  localparam int BLK_OFF_W = 15;
  localparam int PART_SHIFT = 18;
  localparam int QRY_W = 6;
  localparam int QRY_DEPTH = 64;
  // Output modes of a partition
  typedef enum logic [2:0] {
    FQTR_ARRAY = 3'h1,
    FQTR_QUERY = 3'h2,
    FQTR_STATUS = 3'h4
  } fqtr_mode_e;
  // Bus command codes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_QUERY = 8'h98;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  // Query offsets
  localparam logic [QRY_W-1:0] OFS_MFR = 6'h00;
  localparam logic [QRY_W-1:0] OFS_DEV = 6'h01;
  localparam logic [QRY_W-1:0] OFS_BSR = 6'h02;
  localparam logic [QRY_W-1:0] OFS_RSV_LO = 6'h04;
  localparam logic [QRY_W-1:0] OFS_RSV_HI = 6'h0F;
  localparam logic [QRY_W-1:0] OFS_ID = 6'h10;
  localparam logic [QRY_W-1:0] OFS_PTR = 6'h15;
  localparam logic [QRY_W-1:0] OFS_SYS = 6'h1B;
  localparam logic [QRY_W-1:0] OFS_GEO = 6'h27;
  localparam int LOCK_BIT = 0;
  localparam int LOCKDOWN_BIT = 1;
  localparam logic [BYTE_W-1:0] HIGH_BYTE_FILL = 8'h00;
  localparam logic [BYTE_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [BYTE_W-1:0] EXT_TABLE_OFS = 8'h39;
endpackage

//--- hdl/fqtr_rom.sv
`timescale 1ns/1ps
module fqtr_rom (
  input wire logic [fqtr_pkg::QRY_W-1:0] ofs_i,
  input wire logic [fqtr_pkg::BYTE_W-1:0] mfr_i,
  input wire logic [fqtr_pkg::BYTE_W-1:0] dev_i,
  output logic [fqtr_pkg::BYTE_W-1:0] byte_o
);
  // Multi-byte fields are stored LSB at the lower offset
  always_comb
  begin
    case (ofs_i)
      fqtr_pkg::OFS_MFR: byte_o = mfr_i;
      fqtr_pkg::OFS_DEV: byte_o = dev_i;
      6'h10: byte_o = 8'h51;
      6'h11: byte_o = 8'h52;
      6'h12: byte_o = 8'h59;
      6'h13: byte_o = 8'h03;
      6'h14: byte_o = 8'h00;
      fqtr_pkg::OFS_PTR: byte_o = fqtr_pkg::EXT_TABLE_OFS;
      6'h16: byte_o = 8'h00;
      6'h1B: byte_o = 8'h17;
      6'h1C: byte_o = 8'h19;
      6'h1D: byte_o = 8'hB4;
      6'h1E: byte_o = 8'hC6;
      6'h1F: byte_o = 8'h04;
      6'h21: byte_o = 8'h0A;
      6'h23: byte_o = 8'h04;
      6'h25: byte_o = 8'h03;
      // Geometry contents are not modelled; a parameter could fill them later
      default: byte_o = fqtr_pkg::ZERO_BYTE;
    endcase
  end
endmodule

//--- hdl/fqtr_bsr.sv
`timescale 1ns/1ps
module fqtr_bsr (
  input wire logic [fqtr_pkg::BLK_W-1:0] blk_i,
  input wire logic [(1<<fqtr_pkg::BLK_W)-1:0] lock_i,
  input wire logic [(1<<fqtr_pkg::BLK_W)-1:0] lockdown_i,
  output logic [fqtr_pkg::BYTE_W-1:0] byte_o
);
  always_comb
  begin
    byte_o = fqtr_pkg::ZERO_BYTE;
    byte_o[fqtr_pkg::LOCK_BIT] = lock_i[blk_i];
    byte_o[fqtr_pkg::LOCKDOWN_BIT] = lockdown_i[blk_i];
  end
endmodule

//--- test/fqtr_top_properties.sv
`timescale 1ns/1ps
module fqtr_top_properties (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [21:0] addr_i,
  input wire logic rd_i,
  input wire logic [15:0] array_data_i,
  input wire logic [7:0] status_data_i,
  input wire logic [127:0] lock_flag_i,
  input wire logic [127:0] lockdown_flag_i,
  input wire logic [7:0] low_data_byte_lines_o,
  input wire logic [7:0] high_data_byte_lines_o,
  input wire logic rd_valid_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // Mode is not visible here, so array and status bytes stay legal
  property p_byte(ofs, val);
    $past(addr_i[14:0], 3) == ofs |-> low_data_byte_lines_o == val
      || low_data_byte_lines_o == $past(array_data_i[7:0], 3)
      || low_data_byte_lines_o == $past(status_data_i, 3);
  endproperty
  a_id_first: assert property (p_byte(15'h0010, 8'h51)) else $error("bad byte at 10");
  a_id_third: assert property (p_byte(15'h0012, 8'h59)) else $error("bad byte at 12");
  a_field_low: assert property (p_byte(15'h0013, 8'h03)) else $error("bad byte at 13");
  a_ptr_low: assert property (p_byte(15'h0015, 8'h39)) else $error("bad byte at 15");
  a_sys_start: assert property (p_byte(15'h001B, 8'h17)) else $error("bad byte at 1B");
  a_rsv_zero: assert property (p_byte(15'h0004, 8'h00)) else $error("bad byte at 04");
  a_blk_status: assert property (p_byte(15'h0002, {6'h00,
    $past(lockdown_flag_i[addr_i[21:15]], 3), $past(lock_flag_i[addr_i[21:15]], 3)}))
    else $error("bad block status");
  a_high_zero: assert property (high_data_byte_lines_o == 8'h00
    || high_data_byte_lines_o == $past(array_data_i[15:8], 3)) else $error("bad high byte");
  a_valid_delay: assert property (rd_valid_o == $past(rd_i, 3)) else $error("bad valid");
  c_id: cover property ($past(addr_i[14:0], 3) == 15'h0010 && low_data_byte_lines_o == 8'h51);
  c_locked: cover property ($past(addr_i[14:0], 3) == 15'h0002 && low_data_byte_lines_o == 8'h03);
  c_valid: cover property ($rose(rd_valid_o));
endmodule
bind fqtr_top fqtr_top_properties u_chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
  .addr_i(addr_i), .rd_i(rd_i), .array_data_i(array_data_i), .status_data_i(status_data_i),
  .lock_flag_i(lock_flag_i), .lockdown_flag_i(lockdown_flag_i), .rd_valid_o(rd_valid_o),
  .low_data_byte_lines_o(low_data_byte_lines_o), .high_data_byte_lines_o(high_data_byte_lines_o));

//--- test/fqtr_host.sv
`timescale 1ns/1ps
module fqtr_host (
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  output logic [21:0] addr_o = 22'h000000,
  output logic [15:0] cmd_o = 16'h0000,
  output logic we_o = 1'b0,
  output logic rd_o = 1'b0
);
  function automatic logic [21:0] bsr_addr(input int blk);
    return 22'(blk * 32768 + 2);
  endfunction
  // Held well past the three-stage sampling of the strobe
  task automatic cmd(input logic [3:0] part, input logic [7:0] code);
    @(negedge clk_i);
    addr_o = {part, 18'h00000};
    cmd_o = {8'h00, code};
    repeat (2) @(negedge clk_i);
    we_o = 1'b1;
    repeat (4) @(negedge clk_i);
    we_o = 1'b0;
    repeat (4) @(negedge clk_i);
    cmd_o = ~cmd_o;
  endtask
  task automatic read(input logic [21:0] a, output logic [15:0] d);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    repeat (4) @(negedge clk_i);
    d = rdata_i;
    rd_o = 1'b0;
  endtask
endmodule

//--- test/tb_fqtr_top.sv
`timescale 1ns/1ps
module tb_fqtr_top;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [21:0] addr;
  logic [15:0] cmd, d;
  wire [15:0] rdata;
  wire vld;
  logic [15:0] arr = 16'hC3A5;
  logic [7:0] st = 8'h96;
  logic [127:0] lock = '0;
  logic [127:0] ldn = '0;
  logic we, rd;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #10 core_clk_i = ~core_clk_i;
  fqtr_top #(.MFR_CODE(8'h3C), .DEV_CODE(8'hC6)) uut (.core_clk_i(core_clk_i),
    .nrst_i(nrst_i), .addr_i(addr), .cmd_data_i(cmd), .cmd_we_i(we), .rd_i(rd),
    .array_data_i(arr), .status_data_i(st), .lock_flag_i(lock), .lockdown_flag_i(ldn),
    .low_data_byte_lines_o(rdata[7:0]), .high_data_byte_lines_o(rdata[15:8]), .rd_valid_o(vld));
  fqtr_host host (.clk_i(core_clk_i), .rdata_i(rdata), .addr_o(addr), .cmd_o(cmd),
    .we_o(we), .rd_o(rd));
  task automatic test_done();
    $display("checked %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic t_query();
    logic [7:0] o[10] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h1B, 8'h00, 8'h01};
    logic [7:0] v[10] = '{8'h51, 8'h52, 8'h59, 8'h03, 8'h00, 8'h39, 8'h00, 8'h17, 8'h3C, 8'hC6};
    chk("idle valid", 16'h0000, {15'h0000, vld});
    host.read(22'h040010, d);
    chk("array at power-up", arr, d);
    chk("read valid", 16'h0001, {15'h0000, vld});
    host.cmd(4'h1, 8'h98);
    foreach (o[i])
    begin
      host.read({14'h0400, o[i]}, d);
      chk("query word", {8'h00, v[i]}, d);
    end
    for (int k = 4; k < 16; k++)
    begin
      host.read(22'h040000 + 22'(k), d);
      chk("reserved word", 16'h0000, d);
    end
    $display("t_query done");
  endtask
  task automatic t_blk_status();
    for (int k = 0; k < 4; k++)
    begin
      lock[9] = k[0];
      ldn[9] = k[1];
      host.read(host.bsr_addr(9), d);
      chk("block status", {14'h0000, k[1:0]}, d);
      host.read(host.bsr_addr(8), d);
      chk("neighbour status", 16'h0000, d);
    end
    $display("t_blk_status done");
  endtask
  task automatic t_modes();
    logic [7:0] c[5] = '{8'h70, 8'h42, 8'h90, 8'hFF, 8'h98};
    logic [15:0] e[5] = '{16'h0096, 16'h0096, 16'h0051, 16'hC3A5, 16'h0051};
    host.read(22'h080010, d);
    chk("other partition array", arr, d);
    foreach (c[i])
    begin
      host.cmd(4'h1, c[i]);
      host.read(22'h040010, d);
      chk("mode output", e[i], d);
    end
    $display("t_modes done");
  endtask
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      err_count++;
      test_done();
    end
  end
  initial
  begin
    repeat (12) @(negedge core_clk_i);
    nrst_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    t_query();
    t_blk_status();
    t_modes();
    test_done();
  end
endmodule
